// ==== common/reset_combiner_pkg.sv ====
/*
  Constants for the system reset combiner: cause bit positions, register
  offsets, glitch filter timing.
  Assumes an AXI4-Lite master on the same clock as the combiner.
*/
// Contract
// - any active source asserts system reset
// - every reset kind sets its cause bit
// - power-on clears causes, sets bit 0
// - software sets or clears causes, no reset
// - master clear low, glitch filtered, resets
// - master clear reset sets external flag
// - software reset keeps clock source selected
// - software reset releases next instruction cycle
// - software reset sets bit 6
// - watchdog timeout resets asynchronously while running
// - watchdog timeout in sleep/idle only wakes
// - watchdog reset sets bit 4
// - hard trap during higher trap: conflict reset
// - trap conflict sets bit 15
// - pin-select versus shadow mismatch resets
// - mismatch reset sets bit 9
// - illegal opcode, uninit reg, security: bit 14
// - illegal opcode resets before execution
package reset_combiner_pkg;
  // ---------------------------------------------------------------
  // cause register fields
  // ---------------------------------------------------------------
  localparam int POWER_ON_BIT   = 0;
  localparam int BROWN_OUT_BIT  = 1;
  localparam int WATCHDOG_BIT   = 4;
  localparam int SOFTWARE_BIT   = 6;
  localparam int EXTERNAL_BIT   = 7;
  localparam int MISMATCH_BIT   = 9;
  localparam int ILLEGAL_BIT    = 14;
  localparam int TRAP_BIT       = 15;
  localparam logic [15:0] CAUSE_MASK  = 16'hc2d3;
  localparam logic [15:0] CAUSE_POR   = 16'h0001;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] CAUSE_OFFS   = 4'h0;
  localparam logic [3:0] STATE_OFFS   = 4'h4;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int CLEAR_PIN_MIN_NS = 2000;
  localparam int CLEAR_PIN_CYCLES = (CLEAR_PIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HARD_TRAP_LO   = 13;
  localparam int HARD_TRAP_HI   = 15;
  localparam logic [1:0] OKAY   = 2'b00;
  localparam logic [1:0] SLVERR = 2'b10;
endpackage

// ==== core/system_reset_combiner.sv ====
/*
  System reset combiner: merges all reset sources into one system reset,
  records causes, exposes them over AXI4-Lite.
  Assumes rst_n is the raw power-on level; the AXI port and all request
  inputs are on mclk except the master clear pin, which is synchronised.
*/
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
module system_reset_combiner (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        brownOut,
  input  wire logic        masterClearPinN,
  input  wire logic        resetInstr,
  input  wire logic        watchdogTimeout,
  input  wire logic        sleepOrIdle,
  input  wire logic [3:0]  trapLevel,
  input  wire logic        trapValid,
  input  wire logic [3:0]  trapInService,
  input  wire logic        trapBusy,
  input  wire logic [15:0] pinSelect,
  input  wire logic [15:0] pinSelectShadow,
  input  wire logic        opcodeIllegal,
  input  wire logic        uninitRegAccess,
  input  wire logic        securityViolation,
  output logic             systemResetSignal,
  output logic             clockReinit,
  output logic             wakeup,
  output logic             execInhibit,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ---------------------------------------------------------------
  // master clear synchroniser and glitch filter
  // ---------------------------------------------------------------
  logic        clrPinMeta_r;
  logic        clrPinSync_r;
  logic [15:0] clrPinCount_r;
  logic        clrPinReset_r;

  // synchroniser resets to the idle high level of the pin
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clrPinMeta_r <= 1'b1;
      clrPinSync_r <= 1'b1;
    end else begin
      clrPinMeta_r <= masterClearPinN;
      clrPinSync_r <= clrPinMeta_r;
    end
  end

  // low level must last the minimum width before a reset is raised
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clrPinCount_r <= 16'h0000;
      clrPinReset_r <= 1'b0;
    end else if (clrPinSync_r) begin
      clrPinCount_r <= 16'h0000;
      clrPinReset_r <= 1'b0;
    end else if (clrPinCount_r >= 16'(reset_combiner_pkg::CLEAR_PIN_CYCLES - 1)) begin
      clrPinReset_r <= 1'b1;
    end else begin
      clrPinCount_r <= clrPinCount_r + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // source detection
  // ---------------------------------------------------------------
  logic hardTrap;
  logic trapConflict;
  logic mismatch;
  logic illegalCond;
  logic watchdogReset;
  logic swPulse_r;
  logic instrPrev_r;

  assign hardTrap = trapValid
      && (trapLevel >= 4'(reset_combiner_pkg::HARD_TRAP_LO))
      && (trapLevel <= 4'(reset_combiner_pkg::HARD_TRAP_HI));
  assign trapConflict = hardTrap && trapBusy && (trapLevel < trapInService);
  assign mismatch = pinSelect != pinSelectShadow;
  assign illegalCond = opcodeIllegal || uninitRegAccess || securityViolation;
  assign execInhibit = opcodeIllegal;
  assign watchdogReset = watchdogTimeout && !sleepOrIdle;
  assign wakeup = watchdogTimeout && sleepOrIdle;

  // software reset held exactly one instruction cycle
  // fires once per rising edge of the request, so a held request cannot re-trigger
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      instrPrev_r <= 1'b0;
      swPulse_r   <= 1'b0;
    end else begin
      instrPrev_r <= resetInstr;
      swPulse_r   <= resetInstr && !instrPrev_r;
    end
  end

  // watchdog path is combinational so it asserts without a clock edge
  assign systemResetSignal = !rst_n || brownOut || clrPinReset_r || swPulse_r
      || watchdogReset || trapConflict || mismatch || illegalCond;
  // only power-on and brown-out reinitialise the clock source
  assign clockReinit = !rst_n || brownOut;

  // ---------------------------------------------------------------
  // reset cause register
  // ---------------------------------------------------------------
  logic [15:0] cause_r;
  logic [15:0] causeSet;
  logic [15:0] causeWr;
  logic        wrCause;
  logic [31:0] wdataHeld_r;
  logic [3:0]  wstrbHeld_r;

  always_comb begin
    causeSet = 16'h0000;
    causeSet[reset_combiner_pkg::BROWN_OUT_BIT] = brownOut;
    causeSet[reset_combiner_pkg::EXTERNAL_BIT]  = clrPinReset_r;
    causeSet[reset_combiner_pkg::SOFTWARE_BIT]  = swPulse_r;
    causeSet[reset_combiner_pkg::WATCHDOG_BIT]  = watchdogReset;
    causeSet[reset_combiner_pkg::TRAP_BIT]      = trapConflict;
    causeSet[reset_combiner_pkg::MISMATCH_BIT]  = mismatch;
    causeSet[reset_combiner_pkg::ILLEGAL_BIT]   = illegalCond;
  end

  always_comb begin
    causeWr = cause_r;
    if (wstrbHeld_r[0]) begin
      causeWr[7:0] = wdataHeld_r[7:0];
    end
    if (wstrbHeld_r[1]) begin
      causeWr[15:8] = wdataHeld_r[15:8];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cause_r <= reset_combiner_pkg::CAUSE_POR;
    end else begin
      // set wins over a concurrent software clear; other bits hold
      cause_r <= ((wrCause ? causeWr : cause_r) | causeSet)
          & reset_combiner_pkg::CAUSE_MASK;
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  logic       awHave_r;
  logic       wHave_r;
  logic [3:0] awaddrHeld_r;

  assign s_axi_awready = !awHave_r && !s_axi_bvalid;
  assign s_axi_wready  = !wHave_r && !s_axi_bvalid;
  assign wrCause = awHave_r && wHave_r && (awaddrHeld_r == reset_combiner_pkg::CAUSE_OFFS);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      awHave_r     <= 1'b0;
      wHave_r      <= 1'b0;
      awaddrHeld_r <= 4'h0;
      wdataHeld_r  <= 32'h00000000;
      wstrbHeld_r  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_r     <= 1'b1;
        awaddrHeld_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_r     <= 1'b1;
        wdataHeld_r <= s_axi_wdata;
        wstrbHeld_r <= s_axi_wstrb;
      end
      if (awHave_r && wHave_r) begin
        awHave_r     <= 1'b0;
        wHave_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddrHeld_r == reset_combiner_pkg::CAUSE_OFFS)
            ? reset_combiner_pkg::OKAY : reset_combiner_pkg::SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= reset_combiner_pkg::OKAY;
      unique case (s_axi_araddr)
        reset_combiner_pkg::CAUSE_OFFS: s_axi_rdata <= {16'h0000, cause_r};
        reset_combiner_pkg::STATE_OFFS: s_axi_rdata <= {28'h0000000, sleepOrIdle,
            clrPinReset_r, swPulse_r, systemResetSignal};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= reset_combiner_pkg::SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence swReq;
    resetInstr && !instrPrev_r;
  endsequence

  sequence swRelease;
    swPulse_r ##1 !swPulse_r;
  endsequence

  sequence wrLand;
    wrCause && (causeSet == 16'h0000);
  endsequence

  sequence pinHeld;
    clrPinReset_r && !clrPinSync_r;
  endsequence

  a_sw_one_cycle: assert property (@(posedge mclk) disable iff (!rst_n)
    swReq |=> swRelease)
    else $error("software reset not one cycle");
  a_sw_cause_set: assert property (@(posedge mclk) disable iff (!rst_n)
    swPulse_r |=> cause_r[reset_combiner_pkg::SOFTWARE_BIT])
    else $error("software cause not set");
  a_wdt_reset_now: assert property (@(posedge mclk) disable iff (!rst_n)
    (watchdogTimeout && !sleepOrIdle) |-> systemResetSignal)
    else $error("watchdog did not reset");
  a_wdt_sleep_wake: assert property (@(posedge mclk) disable iff (!rst_n)
    (watchdogTimeout && sleepOrIdle) |=> !cause_r[reset_combiner_pkg::WATCHDOG_BIT]
        || $past(cause_r[reset_combiner_pkg::WATCHDOG_BIT]) || $past(wrCause))
    else $error("watchdog in sleep recorded a reset");
  a_trap_cause_set: assert property (@(posedge mclk) disable iff (!rst_n)
    trapConflict |=> cause_r[reset_combiner_pkg::TRAP_BIT])
    else $error("trap conflict cause not set");
  a_mismatch_cause_set: assert property (@(posedge mclk) disable iff (!rst_n)
    (pinSelect != pinSelectShadow) |-> systemResetSignal
        ##1 cause_r[reset_combiner_pkg::MISMATCH_BIT])
    else $error("mismatch not handled");
  a_illegal_cause_set: assert property (@(posedge mclk) disable iff (!rst_n)
    opcodeIllegal |-> execInhibit ##1 cause_r[reset_combiner_pkg::ILLEGAL_BIT])
    else $error("illegal condition not handled");
  a_pin_filter_min: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(clrPinReset_r) |-> clrPinCount_r == 16'(reset_combiner_pkg::CLEAR_PIN_CYCLES - 1))
    else $error("master clear reset too early");

  a_pin_cause_set: assert property (@(posedge mclk) disable iff (!rst_n)
    clrPinReset_r |=> cause_r[reset_combiner_pkg::EXTERNAL_BIT])
    else $error("external cause not set");

  a_cause_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (!wrCause && causeSet == 16'h0000) |=> cause_r == $past(cause_r))
    else $error("cause bits changed without event");

  a_any_src_reset: assert property (@(posedge mclk) disable iff (!rst_n)
    (brownOut || clrPinReset_r || swPulse_r || trapConflict || illegalCond)
        |-> systemResetSignal)
    else $error("active source without system reset");

  a_por_value: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(rst_n) |-> cause_r == reset_combiner_pkg::CAUSE_POR)
    else $error("power-on cause value wrong");

  a_write_lands: assert property (@(posedge mclk) disable iff (!rst_n)
    wrLand |=> cause_r == ($past(causeWr) & reset_combiner_pkg::CAUSE_MASK))
    else $error("software write to causes lost");

  a_pin_held: assert property (@(posedge mclk) disable iff (!rst_n)
    pinHeld |=> clrPinReset_r)
    else $error("master clear reset dropped while pin low");

  a_pin_release: assert property (@(posedge mclk) disable iff (!rst_n)
    clrPinSync_r |=> !clrPinReset_r)
    else $error("master clear reset kept after pin high");

  a_filter_short: assert property (@(posedge mclk) disable iff (!rst_n)
    (!clrPinReset_r
        && clrPinCount_r < 16'(reset_combiner_pkg::CLEAR_PIN_CYCLES - 1))
        |=> !clrPinReset_r)
    else $error("short master clear pulse passed filter");

  a_clock_kept: assert property (@(posedge mclk) disable iff (!rst_n)
    (swPulse_r && !brownOut) |-> !clockReinit)
    else $error("software reset reinitialised clock");

  a_brown_clock: assert property (@(posedge mclk) disable iff (!rst_n)
    brownOut |-> clockReinit)
    else $error("brown-out kept clock source");

  a_brown_cause: assert property (@(posedge mclk) disable iff (!rst_n)
    brownOut |=> cause_r[reset_combiner_pkg::BROWN_OUT_BIT])
    else $error("brown-out cause not set");

  a_wdt_cause_set: assert property (@(posedge mclk) disable iff (!rst_n)
    watchdogReset |=> cause_r[reset_combiner_pkg::WATCHDOG_BIT])
    else $error("watchdog cause not set");

  a_wdt_wake_only: assert property (@(posedge mclk) disable iff (!rst_n)
    (watchdogTimeout && sleepOrIdle) |-> wakeup && !watchdogReset)
    else $error("watchdog in sleep did not only wake");

  a_trap_reset: assert property (@(posedge mclk) disable iff (!rst_n)
    trapConflict |-> systemResetSignal)
    else $error("trap conflict without reset");

  a_trap_range: assert property (@(posedge mclk) disable iff (!rst_n)
    trapConflict |-> trapLevel >= 4'(reset_combiner_pkg::HARD_TRAP_LO))
    else $error("trap conflict from soft trap");

  a_cause_mask: assert property (@(posedge mclk) disable iff (!rst_n)
    (cause_r & ~reset_combiner_pkg::CAUSE_MASK) == 16'h0000)
    else $error("unused cause bit set");

  a_exec_inhibit: assert property (@(posedge mclk) disable iff (!rst_n)
    opcodeIllegal |-> execInhibit && systemResetSignal)
    else $error("illegal opcode not blocked");

  a_uninit_cause: assert property (@(posedge mclk) disable iff (!rst_n)
    (uninitRegAccess || securityViolation) |=> cause_r[reset_combiner_pkg::ILLEGAL_BIT])
    else $error("illegal condition cause not set");

  a_read_cause: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == reset_combiner_pkg::CAUSE_OFFS)
        |=> s_axi_rvalid && s_axi_rdata[15:0] == $past(cause_r))
    else $error("cause read data wrong");

  a_write_resp: assert property (@(posedge mclk) disable iff (!rst_n)
    (awHave_r && wHave_r) |=> s_axi_bvalid)
    else $error("write response missing");

  a_ready_refuse: assert property (@(posedge mclk) disable iff (!rst_n)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");

  a_bvalid_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
    else $error("write response dropped early");

  a_rvalid_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid)
    else $error("read response dropped early");

  a_sw_rearm: assert property (@(posedge mclk) disable iff (!rst_n)
    swPulse_r |=> !swPulse_r)
    else $error("software reset held too long");

endmodule // system_reset_combiner

// ==== verification/supervisor_model.sv ====
/*
  Supervisory circuit model: pulls the master clear pin low for a set
  number of cycles on request, drives it high otherwise.
  Assumes mclk comes from the bench.
*/
`timescale 1ns/1ps
module supervisor_model (
  input  wire logic        mclk,
  input  wire logic        go,
  input  wire logic [15:0] holdCycles,
  output logic             masterClearPinN
);
  // ------------------------------
  // pulse generator
  // ------------------------------
  int cnt = 0;
  initial masterClearPinN = 1'b1;
  always @(posedge mclk) begin
    if (go) begin
      cnt <= holdCycles;
      masterClearPinN <= 1'b0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      masterClearPinN <= 1'b1;
    end
  end
endmodule // supervisor_model

// ==== verification/tb_system_reset_combiner.sv ====
/*
  Self-checking bench for the reset combiner: every reset source, the
  supervisor model and the register bus, compared with a cause model.
  Assumes the design package is compiled first.
*/
`timescale 1ns/1ps
module tb_system_reset_combiner;
  logic        mclk = 0, rst_n = 0, brownOut = 0, resetInstr = 0, go = 0;
  logic        watchdogTimeout = 0, sleepOrIdle = 0, trapValid = 0, trapBusy = 0;
  logic        opcodeIllegal = 0, uninitRegAccess = 0, securityViolation = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, seenRst = 0;
  logic [3:0]  trapLevel = 0, trapInService = 0, awaddr = 0, araddr = 0, wstrb = 0;
  logic [15:0] pinSelect = 0, pinSelectShadow = 0, holdCycles = 0;
  logic [31:0] wdata = 0, rd;
  logic [1:0]  rr;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire         pinN, system_reset_signal, clkRe, wake, inhibit, awready, wready, bvalid, arready, rvalid;
  int          miscompares = 0, checks_done = 0, cyc = 0, expCause = 1, v;
  int          bits[7] = '{1, 4, 9, 14, 14, 14, 15};

  system_reset_combiner i_dut (
    .mclk(mclk), .rst_n(rst_n), .brownOut(brownOut), .masterClearPinN(pinN),
    .resetInstr(resetInstr), .watchdogTimeout(watchdogTimeout), .sleepOrIdle(sleepOrIdle),
    .trapLevel(trapLevel), .trapValid(trapValid), .trapInService(trapInService),
    .trapBusy(trapBusy), .pinSelect(pinSelect), .pinSelectShadow(pinSelectShadow),
    .opcodeIllegal(opcodeIllegal), .uninitRegAccess(uninitRegAccess),
    .securityViolation(securityViolation), .systemResetSignal(system_reset_signal), .clockReinit(clkRe),
    .wakeup(wake), .execInhibit(inhibit), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  supervisor_model i_sup (.mclk(mclk), .go(go), .holdCycles(holdCycles), .masterClearPinN(pinN));

  // ------------------------------
  // clock, timeout, helpers
  // ------------------------------
  always #5 mclk = ~mclk;
  always @(negedge mclk) if (system_reset_signal === 1'b1) seenRst = 1'b1;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic final_report();
    if (miscompares == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (bvalid !== 1'b1);
    rr = bresp;
    bready <= 0;
    @(posedge mclk);
    chk("bresp", rr, a == 4'h0 ? reset_combiner_pkg::OKAY : reset_combiner_pkg::SLVERR);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rr = rresp;
    rready <= 0;
    @(posedge mclk);
    chk("rdata", rd, e);
    chk("rresp", rr, a > 4'h4 ? reset_combiner_pkg::SLVERR : reset_combiner_pkg::OKAY);
  endtask
  task automatic src(input int k, input int b);
    @(posedge mclk);
    case (k)
      0: brownOut <= 1;
      1: watchdogTimeout <= 1;
      2: pinSelect <= pinSelectShadow ^ (16'h1 << ($urandom % 16));
      3: opcodeIllegal <= 1;
      4: uninitRegAccess <= 1;
      5: securityViolation <= 1;
      default: {trapBusy, trapInService, trapValid, trapLevel} <= {1'b1, 4'hf, 1'b1, 4'hd};
    endcase
    @(negedge mclk);
    chk("system_reset_signal", system_reset_signal, 1);
    chk("clkRe", clkRe, k == 0);
    chk("inhibit", inhibit, k == 3);
    @(posedge mclk);
    {brownOut, watchdogTimeout, opcodeIllegal, uninitRegAccess, securityViolation} <= 0;
    {trapBusy, trapValid} <= 0;
    pinSelect <= pinSelectShadow;
    expCause = expCause | (1 << b);
    rdchk(4'h0, expCause);
  endtask

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    v = $urandom(1906);
    v = $urandom;
    repeat (8) @(posedge mclk);
    chk("rstClk", clkRe, 1);
    rst_n <= 1;
    pinSelect <= v[15:0];
    pinSelectShadow <= v[15:0];
    @(posedge mclk);
    rdchk(4'h0, 32'h1);
    seenRst = 0;
    axw(4'h0, 32'hffff, 4'h3);
    rdchk(4'h0, reset_combiner_pkg::CAUSE_MASK);
    axw(4'h0, 32'h0, 4'h1);
    rdchk(4'h0, reset_combiner_pkg::CAUSE_MASK & 16'hff00);
    axw(4'h8, 32'hffff, 4'h3);
    axw(4'h0, 32'h0, 4'h3);
    rdchk(4'h0, 32'h0);
    rdchk(4'h8, 32'h0);
    chk("swSet", seenRst, 0);
    expCause = 0;
    sleepOrIdle <= 1;
    watchdogTimeout <= 1;
    {trapBusy, trapInService, trapValid, trapLevel} <= {1'b1, 4'hd, 1'b1, 4'he};
    @(negedge mclk);
    chk("wake", wake, 1);
    @(posedge mclk);
    rdchk(4'h4, 32'h8);
    {trapInService, trapLevel} <= {4'hf, 4'hc};
    watchdogTimeout <= 0;
    sleepOrIdle <= 0;
    @(posedge mclk);
    trapValid <= 0;
    rdchk(4'h0, 32'h0);
    chk("noRst", seenRst, 0);
    foreach (bits[i]) src(i, bits[i]);
    resetInstr <= 1;
    @(negedge mclk);
    chk("swIdle", system_reset_signal, 0);
    @(negedge mclk);
    chk("swPulse", system_reset_signal, 1);
    chk("swClk", clkRe, 0);
    @(negedge mclk);
    chk("swRelease", system_reset_signal, 0);
    @(posedge mclk);
    resetInstr <= 0;
    expCause = expCause | 32'h40;
    rdchk(4'h0, expCause);
    seenRst = 0;
    holdCycles <= 16'd100;
    go <= 1;
    @(posedge mclk);
    go <= 0;
    repeat (120) @(posedge mclk);
    chk("pinShort", seenRst, 0);
    holdCycles <= 16'd300;
    go <= 1;
    @(posedge mclk);
    go <= 0;
    repeat (250) @(posedge mclk);
    chk("pinLong", system_reset_signal, 1);
    repeat (60) @(posedge mclk);
    expCause = expCause | 32'h80;
    rdchk(4'h0, expCause);
    rst_n <= 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1;
    @(posedge mclk);
    rdchk(4'h0, 32'h1);
    final_report();
  end
endmodule // tb_system_reset_combiner
